/* File: rtl/qsd_pkg.sv */
/*
 * qsd_pkg: shared constants, register map and carrier types of the quad
 * sink driver control block.
 * assumes a single 50 MHz sys_clk domain and classic wishbone access.
 */
package qsd_pkg;

    localparam int unsigned NUM_CH          = 4;
    localparam int unsigned CLK_HZ          = 50_000_000;

    // overcurrent filter time in ns, retry hold time in us
    localparam int unsigned OC_FILTER_NS    = 3500;
    localparam int unsigned FAULT_HOLD_US   = 1200;
    // filter is a least time: round up
    localparam int unsigned OC_FILTER_CYC   =
        (OC_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned FAULT_HOLD_CYC  =
        FAULT_HOLD_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CNT_W           = 17;

    // register byte offsets
    localparam logic [3:0] REG_CTRL         = 4'h0;
    localparam logic [3:0] REG_STAT         = 4'h4;
    localparam logic [3:0] REG_EVT          = 4'h8;
    localparam logic [3:0] REG_MASK         = 4'hC;

    // ctrl fields
    localparam int unsigned CTRL_CH_LSB     = 0;
    localparam int unsigned CTRL_EN_LOW_BIT = 4;
    localparam int unsigned CTRL_RST_BIT    = 5;
    localparam int unsigned CTRL_SRC_BIT    = 6;
    localparam logic [6:0]  CTRL_RESET      = 7'h00;

    // event bits: 0..3 per-channel overcurrent trip, 4 thermal trip,
    // 5 low-supply lockout, 6 fault release
    localparam int unsigned EVT_THERM_BIT   = 4;
    localparam int unsigned EVT_LOCK_BIT    = 5;
    localparam int unsigned EVT_REL_BIT     = 6;
    localparam int unsigned EVT_W           = 7;
    localparam logic [6:0]  MASK_RESET      = 7'h00;

    typedef enum logic [1:0] {
        CH_RUN   = 2'b00,
        CH_FILT  = 2'b01,
        CH_HOLD  = 2'b10
    } qsd_ch_state_t;

    typedef struct packed {
        logic               cyc;
        logic               stb;
        logic               we;
        logic [3:0]         adr;
        logic [3:0]         sel;
        logic [31:0]        dat;
    } qsd_wb_req_t;

    typedef struct packed {
        logic               ack;
        logic [31:0]        dat;
    } qsd_wb_rsp_t;

endpackage

/* File: rtl/qsd_channel.sv */
/*
 * qsd_channel: one channel's overcurrent filter and retry timer.
 * assumes the parent applies the combined logic reset and the enable gate.
 */
module qsd_channel (
    // clock and reset
    input  wire logic   sys_clk,
    input  wire logic   srst,
    // channel
    input  wire logic   driveReq,
    input  wire logic   limitActive,
    output logic        channelOn,
    output logic        ocFault,
    output logic        tripPulse
);

    typedef struct packed {
        qsd_pkg::qsd_ch_state_t  state;
        logic [qsd_pkg::CNT_W-1:0] cnt;
        logic                    trip;
    } qsd_ch_reg_t;

    qsd_ch_reg_t st_r;
    qsd_ch_reg_t st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.trip = 1'b0;
        case (st_r.state)
            qsd_pkg::CH_RUN: begin
                if (driveReq && limitActive) begin
                    st_nxt.state = qsd_pkg::CH_FILT;
                    st_nxt.cnt   = qsd_pkg::CNT_W'(1);
                end
            end
            qsd_pkg::CH_FILT: begin
                // a single gap in the limit restarts the filter
                if (!(driveReq && limitActive)) begin
                    st_nxt.state = qsd_pkg::CH_RUN;
                end else if (st_r.cnt >=
                             qsd_pkg::CNT_W'(qsd_pkg::OC_FILTER_CYC)) begin
                    st_nxt.state = qsd_pkg::CH_HOLD;
                    st_nxt.cnt   = qsd_pkg::CNT_W'(1);
                    st_nxt.trip  = 1'b1;
                end else begin
                    st_nxt.cnt = st_r.cnt + qsd_pkg::CNT_W'(1);
                end
            end
            qsd_pkg::CH_HOLD: begin
                if (st_r.cnt >= qsd_pkg::CNT_W'(qsd_pkg::FAULT_HOLD_CYC)) begin
                    st_nxt.state = qsd_pkg::CH_RUN;
                end else begin
                    st_nxt.cnt = st_r.cnt + qsd_pkg::CNT_W'(1);
                end
            end
            default: st_nxt.state = qsd_pkg::CH_RUN;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r <= '{qsd_pkg::CH_RUN, '0, 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // driver disabled while holding off after a trip
    assign channelOn = driveReq && (st_r.state != qsd_pkg::CH_HOLD);
    assign ocFault   = (st_r.state == qsd_pkg::CH_HOLD);
    assign tripPulse = st_r.trip;

endmodule

/* File: rtl/qsd_top.sv */
/*
 * qsd_top: control and protection logic of a four-channel low-side
 * sink driver, with a wishbone register slave and a level interrupt.
 * assumes pins and analog sense flags are synchronous to sys_clk; the
 * pull-downs on the enable and reset pins are modelled by the pad ring.
 */
// Summary of operation
// - outputs are on only while the active-low drive enable is low
// - four independent channels, each input switching its own sink
// - limit held beyond the filter time disables the channel, asserts fault
// - tripped channel stays off for the hold time, then recovers itself
// - reset or supply loss clears an overcurrent fault at once
// - thermal trip turns all sinks off and asserts fault until it clears
// - low-supply lockout disables everything and holds logic in reset
// - active-high reset input resets internal logic including faults
// - while reset is asserted channel and enable inputs are ignored
// - power-up reset resets internal logic without the reset pin
// - undriven enable and reset pins read low: enabled, not reset
module qsd_top (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       srst,
    // pins from controller
    input  wire logic [qsd_pkg::NUM_CH-1:0] channelControl,
    input  wire logic                       driveEnableLow,
    input  wire logic                       resetPin,
    // analog sense
    input  wire logic [qsd_pkg::NUM_CH-1:0] overcurrentTrip,
    input  wire logic                       thermalTrip,
    input  wire logic                       lowSupplyLockout,
    input  wire logic                       powerUpReset,
    // outputs
    output logic      [qsd_pkg::NUM_CH-1:0] channelSink,
    output logic                            faultFlagLowOut,
    output logic                            faultFlagLowOe,
    output logic                            irq,
    // wishbone slave
    input  wire qsd_pkg::qsd_wb_req_t       wbReq,
    output qsd_pkg::qsd_wb_rsp_t            wbRsp
);

    typedef struct packed {
        logic [6:0]                   ctrl;
        logic [qsd_pkg::EVT_W-1:0]    evt;
        logic [qsd_pkg::EVT_W-1:0]    mask;
        logic                         lockPrev;
        logic                         thermPrev;
        logic                         faultPrev;
        logic                         ack;
        logic [31:0]                  rdat;
        logic [qsd_pkg::NUM_CH-1:0]   sink;
        logic                         faultLow;
    } qsd_top_reg_t;

    qsd_top_reg_t st_r;
    qsd_top_reg_t st_nxt;

    logic                       ctlRst;
    logic                       logicRst;
    logic [qsd_pkg::NUM_CH-1:0] chReq;
    logic [qsd_pkg::NUM_CH-1:0] chOn;
    logic [qsd_pkg::NUM_CH-1:0] chFault;
    logic [qsd_pkg::NUM_CH-1:0] chTrip;
    logic                       enLow;
    logic [qsd_pkg::NUM_CH-1:0] chIn;
    logic                       anyFault;
    logic                       busHit;
    logic [31:0]                statWord;

    // software may take the channel and enable pins' place when the source bit is set
    // a low pin means enabled and out of reset, as the pad pull-downs give
    assign enLow  = st_r.ctrl[qsd_pkg::CTRL_SRC_BIT] ?
                    st_r.ctrl[qsd_pkg::CTRL_EN_LOW_BIT] : driveEnableLow;
    assign chIn   = st_r.ctrl[qsd_pkg::CTRL_SRC_BIT] ?
                    st_r.ctrl[qsd_pkg::CTRL_CH_LSB +: qsd_pkg::NUM_CH] :
                    channelControl;
    // pin or software reset
    assign ctlRst = resetPin || st_r.ctrl[qsd_pkg::CTRL_RST_BIT];
    // every internal reset source clears the driver logic
    assign logicRst = srst || powerUpReset || lowSupplyLockout
                      || ctlRst;

    // inputs are ignored while reset is held
    assign chReq = (logicRst || enLow) ? '0 : chIn;

    genvar gi;
    generate
        for (gi = 0; gi < qsd_pkg::NUM_CH; gi++) begin : g_ch
            qsd_channel u_ch (
                .sys_clk     (sys_clk),
                .srst        (logicRst),
                .driveReq    (chReq[gi]),
                .limitActive (overcurrentTrip[gi]),
                .channelOn   (chOn[gi]),
                .ocFault     (chFault[gi]),
                .tripPulse   (chTrip[gi])
            );
        end
    endgenerate

    assign anyFault = (|chFault) || thermalTrip;
    assign busHit   = wbReq.cyc && wbReq.stb && !st_r.ack;

    always_comb begin
        statWord = 32'h0000_0000;
        statWord[3:0] = chFault;
        statWord[4]   = thermalTrip;
        statWord[5]   = lowSupplyLockout;
        statWord[6]   = enLow;
        statWord[7]   = ctlRst;
        statWord[11:8] = st_r.sink;
    end

    always_comb begin
        st_nxt           = st_r;
        st_nxt.ack       = busHit;
        st_nxt.lockPrev  = lowSupplyLockout;
        st_nxt.thermPrev = thermalTrip;
        st_nxt.faultPrev = anyFault;
        // thermal trip forces every sink off; supply lockout too
        st_nxt.sink = (thermalTrip || lowSupplyLockout) ? '0 : chOn;
        // open-drain fault pulled low while any fault stands
        st_nxt.faultLow = !anyFault;

        if (busHit && !wbReq.we) begin
            if (wbReq.adr == qsd_pkg::REG_CTRL) begin
                st_nxt.rdat = {25'h0, st_r.ctrl};
            end else if (wbReq.adr == qsd_pkg::REG_STAT) begin
                st_nxt.rdat = statWord;
            end else if (wbReq.adr == qsd_pkg::REG_EVT) begin
                st_nxt.rdat = {25'h0, st_r.evt};
                st_nxt.evt  = '0;
            end else if (wbReq.adr == qsd_pkg::REG_MASK) begin
                st_nxt.rdat = {25'h0, st_r.mask};
            end else begin
                st_nxt.rdat = 32'h0000_0000;
            end
        end
        if (busHit && wbReq.we && wbReq.sel[0]) begin
            if (wbReq.adr == qsd_pkg::REG_CTRL) begin
                st_nxt.ctrl = wbReq.dat[6:0];
            end else if (wbReq.adr == qsd_pkg::REG_MASK) begin
                st_nxt.mask = wbReq.dat[qsd_pkg::EVT_W-1:0];
            end
        end
        // events set after the read clear so a same-cycle event survives
        st_nxt.evt[3:0] = st_nxt.evt[3:0] | chTrip;
        // own edge history: a standing channel fault must not hide the rise
        if (thermalTrip && !st_r.thermPrev) begin
            st_nxt.evt[qsd_pkg::EVT_THERM_BIT] = 1'b1;
        end
        if (lowSupplyLockout && !st_r.lockPrev) begin
            st_nxt.evt[qsd_pkg::EVT_LOCK_BIT] = 1'b1;
        end
        if (!anyFault && st_r.faultPrev) begin
            st_nxt.evt[qsd_pkg::EVT_REL_BIT] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r <= '{qsd_pkg::CTRL_RESET, '0, qsd_pkg::MASK_RESET,
                      1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_0000, '0, 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign channelSink     = st_r.sink;
    assign faultFlagLowOut = 1'b0;
    // enable is low while driving; high releases the line
    assign faultFlagLowOe  = st_r.faultLow;
    assign irq             = |(st_r.evt & st_r.mask);
    assign wbRsp           = '{st_r.ack, st_r.rdat};

endmodule

/* File: verification/qsd_top_asserts.sv */
/* qsd_top_asserts: port-level checks of the quad sink driver control.
   assumes it is bound to qsd_top, software never selects the CTRL pin
   source and sets the CTRL reset bit only while every channel input is low. */
module qsd_top_asserts (
    // clock and reset
    input wire logic                       sys_clk,
    input wire logic                       srst,
    // pins and sense
    input wire logic [qsd_pkg::NUM_CH-1:0] channelControl,
    input wire logic                       driveEnableLow,
    input wire logic                       resetPin,
    input wire logic [qsd_pkg::NUM_CH-1:0] overcurrentTrip,
    input wire logic                       thermalTrip,
    input wire logic                       lowSupplyLockout,
    input wire logic                       powerUpReset,
    // outputs
    input wire logic [qsd_pkg::NUM_CH-1:0] channelSink,
    input wire logic                       faultFlagLowOut,
    input wire logic                       faultFlagLowOe,
    input wire qsd_pkg::qsd_wb_rsp_t       wbRsp
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic [7:0] limitRun_r;
    logic       quiet;
    assign quiet = !driveEnableLow && !resetPin && !thermalTrip &&
        !lowSupplyLockout && !powerUpReset && faultFlagLowOe;
    // run of limit cycles while channel 0 still sinks; saturates
    always_ff @(posedge sys_clk) begin
        if (srst || !(overcurrentTrip[0] && channelSink[0]))
            limitRun_r <= 8'h00;
        else if (limitRun_r != 8'hFF)
            limitRun_r <= limitRun_r + 8'h01;
    end
    sequence s_quiet;
        quiet ##1 faultFlagLowOe;
    endsequence
    sequence s_hot;
        thermalTrip [*2];
    endsequence
    a_enable_gates: assert property (driveEnableLow |=> channelSink == '0)
        else $error("sinks on while drive enable high");
    a_sink_needs_in: assert property ((channelSink & ~$past(channelControl)) == '0)
        else $error("sink on without its input");
    a_follow_input: assert property (s_quiet |-> channelSink == $past(channelControl))
        else $error("sinks do not follow inputs");
    a_reset_ignores: assert property (resetPin |=> channelSink == '0)
        else $error("sinks on during reset pin");
    a_lockout_off: assert property (lowSupplyLockout |=> channelSink == '0)
        else $error("sinks on during lockout");
    a_thermal_fault: assert property (s_hot |-> channelSink == '0 && !faultFlagLowOe)
        else $error("thermal trip not honoured");
    a_fault_data_low: assert property (faultFlagLowOut == 1'b0)
        else $error("fault pin data not low");
    a_filter_bound: assert property (limitRun_r <= 8'hB4)
        else $error("limit held too long without trip");
    a_ack_pulse: assert property (wbRsp.ack |=> !wbRsp.ack)
        else $error("ack longer than one cycle");
endmodule
bind qsd_top qsd_top_asserts i_qsd_top_asserts (.*);

/* File: verification/qsd_ctl_model.sv */
/* qsd_ctl_model: controller driving the four channel inputs.
   assumes the bench gives wanted levels and a pwm request for channel 3. */
module qsd_ctl_model #(
    parameter int unsigned HALF_CYC = 300
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       srst,
    // requests
    input  wire logic [3:0] want,
    input  wire logic       pwmOn,
    // pins
    output logic      [3:0] channelControl
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned tick = 0;
    // half period of 300 cycles keeps pwm near 83 kHz, never faster
    always @(posedge sys_clk) begin
        if (srst || !pwmOn || tick == HALF_CYC - 1) begin
            tick <= 0;
        end else begin
            tick <= tick + 1;
        end
        if (srst || !pwmOn) begin
            channelControl <= want;
        end else if (tick == HALF_CYC - 1) begin
            channelControl[3] <= ~channelControl[3];
        end
    end
endmodule

/* File: verification/tb_top.sv */
/* tb_top: self-checking bench of the quad sink driver control.
   assumes one 50 MHz clock and the controller model on the pins. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 sys_clk = 1'b0;
    logic                 srst = 1'b1;
    logic [3:0]           want = 4'h0;
    logic                 pwmOn = 1'b0;
    logic [3:0]           channelControl;
    logic                 driveEnableLow = 1'b0;
    logic                 resetPin = 1'b0;
    logic [3:0]           overcurrentTrip = 4'h0;
    logic                 thermalTrip = 1'b0;
    logic                 lowSupplyLockout = 1'b0;
    logic                 powerUpReset = 1'b1;
    logic [3:0]           channelSink;
    logic                 faultFlagLowOut;
    logic                 faultFlagLowOe;
    logic                 irq;
    qsd_pkg::qsd_wb_req_t wbReq = '0;
    qsd_pkg::qsd_wb_rsp_t wbRsp;
    logic [31:0]          rdat;
    logic                 useRd;
    logic [31:0]          expQ[$];
    int                   err_total = 0;
    int                   checks_done = 0;
    event                 chkEv;
    always #10 sys_clk = ~sys_clk;
    qsd_ctl_model i_qsd_ctl_model (.sys_clk(sys_clk), .srst(srst),
        .want(want), .pwmOn(pwmOn), .channelControl(channelControl));
    qsd_top i_qsd_top (.sys_clk(sys_clk), .srst(srst),
        .channelControl(channelControl), .driveEnableLow(driveEnableLow),
        .resetPin(resetPin), .overcurrentTrip(overcurrentTrip),
        .thermalTrip(thermalTrip), .lowSupplyLockout(lowSupplyLockout),
        .powerUpReset(powerUpReset), .channelSink(channelSink),
        .faultFlagLowOut(faultFlagLowOut), .faultFlagLowOe(faultFlagLowOe),
        .irq(irq), .wbReq(wbReq), .wbRsp(wbRsp));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // oldest note against the read data or what is on the outputs now: {irq, sinks, oe}
    always @(chkEv) chk(useRd ? rdat : {26'h0, irq, channelSink,
        faultFlagLowOe}, expQ.pop_front());
    task note(input logic rd, input logic [31:0] e);
        #1;
        useRd = rd;
        expQ.push_back(e);
        ->chkEv;
        @(posedge sys_clk);
    endtask
    task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wbReq <= '{1'b1, 1'b1, we, a, 4'hF, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wbRsp.ack !== 1'b1 && n < 20);
        if (n == 20) err_total++;
        rdat = wbRsp.dat;
        wbReq <= '0;
        @(posedge sys_clk);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge sys_clk);
        err_total++;
        end_sim();
    end
    initial begin
        logic [3:0] v;
        logic       en;
        int         i;
        v = $urandom(32'h4C94);
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        powerUpReset <= 1'b0;
        @(posedge sys_clk);
        note(0, 32'h01);
        wb(1, qsd_pkg::REG_MASK, 32'h10);
        wb(0, qsd_pkg::REG_MASK, 32'h0);
        note(1, 32'h10);
        wb(0, 4'h2, 32'h0);
        note(1, 32'h0);
        $display("test registers done");
        for (i = 0; i < 12; i++) begin
            {en, v} = 5'($urandom);
            want <= v;
            driveEnableLow <= en;
            repeat (2) @(posedge sys_clk);
            note(0, {27'h0, en ? 4'h0 : v, 1'b1});
        end
        $display("test pins done");
        want <= 4'h1;
        driveEnableLow <= 1'b0;
        repeat (3) @(posedge sys_clk);
        overcurrentTrip <= 4'h1;
        repeat (170) @(posedge sys_clk);
        note(0, 32'h03);
        repeat (9) @(posedge sys_clk);
        overcurrentTrip <= 4'h0;
        pwmOn <= 1'b1;
        note(0, 32'h00);
        repeat (58800) @(posedge sys_clk);
        pwmOn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        note(0, 32'h00);
        repeat (1300) @(posedge sys_clk);
        note(0, 32'h03);
        $display("test overcurrent done");
        for (i = 0; i < 2; i++) begin
            overcurrentTrip <= 4'h1;
            repeat (190) @(posedge sys_clk);
            overcurrentTrip <= 4'h0;
            note(0, i ? 32'h1C : 32'h00);
            resetPin <= (i == 0);
            lowSupplyLockout <= (i == 1);
            want <= 4'hF;
            repeat (3) @(posedge sys_clk);
            note(0, 32'h01);
            resetPin <= 1'b0;
            lowSupplyLockout <= 1'b0;
            repeat (3) @(posedge sys_clk);
            note(0, 32'h1F);
        end
        // software reset clears a pending trip; pins low keep the checker valid
        overcurrentTrip <= 4'h1;
        repeat (190) @(posedge sys_clk);
        overcurrentTrip <= 4'h0;
        want <= 4'h0;
        wb(1, qsd_pkg::REG_CTRL, 32'h20);
        wb(0, qsd_pkg::REG_CTRL, 32'h0);
        note(1, 32'h20);
        wb(0, qsd_pkg::REG_STAT, 32'h0);
        note(1, 32'h80);
        note(0, 32'h01);
        want <= 4'hF;
        wb(1, qsd_pkg::REG_CTRL, 32'h0);
        $display("test fault clear done");
        wb(0, qsd_pkg::REG_EVT, 32'h0);
        note(1, 32'h61);
        thermalTrip <= 1'b1;
        repeat (3) @(posedge sys_clk);
        note(0, 32'h20);
        wb(0, qsd_pkg::REG_EVT, 32'h0);
        note(1, 32'h10);
        note(0, 32'h00);
        thermalTrip <= 1'b0;
        repeat (3) @(posedge sys_clk);
        note(0, 32'h1F);
        $display("test thermal done");
        end_sim();
    end
endmodule
